//--- src/core_pkg.sv
// package: constants, carrier types and opcode decode for the core register/arith slice
// Functional notes
// RULE1 - 8-bit main operand register, reset zero, source and target of most ops
// RULE2 - 8-bit second operand register, reset zero, free scratch storage otherwise
// RULE3 - stack in DATA grows upward; store bumps pointer then writes new location
// RULE4 - stack pointer resets to 0x07, first stacked byte lands at 0x08
// RULE5 - direct address below 0x80 is DATA, 0x80 and above is SFR
// RULE6 - indirect address comes from bank register 0 or 1, reaches 0xFF
// RULE7 - register form picks one of eight current-bank registers by low opcode bits
// RULE8 - page target replaces low 11 bits of the following instruction address
// RULE9 - relative target adds signed byte to following instruction address
// RULE10 - long call and jump carry a full 16-bit destination
// RULE11 - immediate forms take an 8-bit constant, pointer load a 16-bit one
// RULE12 - writes to the flags word set flags exactly as written; the parity bit still reads as main operand parity
// RULE13 - add opcodes 0x24-0x2F with their lengths and cycle counts
// RULE14 - add-with-carry opcodes 0x34-0x3F with lengths and cycle counts
// RULE15 - subtract-with-borrow opcodes 0x94-0x9F with lengths and cycle counts
// RULE16 - AND into main operand, opcodes 0x54-0x5F
// RULE17 - AND into direct byte, 0x52 (2 bytes, 3 cycles), 0x53 (3 bytes, 4 cycles)
// RULE18 - OR into main operand, opcodes 0x44-0x4F
// RULE19 - OR into direct byte, 0x42 (2 bytes, 3 cycles), 0x43 (3 bytes, 4 cycles)
// RULE20 - XOR into main operand, opcodes 0x64-0x6F
// RULE21 - XOR main operand into direct byte, 0x62, 2 bytes, 3 cycles
// RULE22 - XOR immediate into direct byte, 0x63, 3 bytes, 4 cycles
// RULE23 - two-bit bank select in flags word maps banks onto eight-byte DATA regions
// RULE24 - next fetch waits until the instruction's cycle count has elapsed
// RULE25 - uncovered opcodes go to remaining decode, no state changed here
package core_pkg;

  // ----------------------------------------------------------------
  // sfr map and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] SP_ADDR = 8'h81;
  localparam logic [7:0] FLAGS_ADDR = 8'hD0;
  localparam logic [7:0] ACC_ADDR = 8'hE0;
  localparam logic [7:0] SECOND_ADDR = 8'hF0;
  localparam logic [7:0] SP_RESET = 8'h07;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] SECOND_RESET = 8'h00;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [15:0] PC_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // flags word fields and page target width
  // ----------------------------------------------------------------
  localparam int CY_BIT = 7;
  localparam int AC_BIT = 6;
  localparam int BANK_HI = 4;
  localparam int BANK_LO = 3;
  localparam int OV_BIT = 2;
  localparam int PAR_BIT = 0;
  localparam int PAGE_BITS = 11;

  // ----------------------------------------------------------------
  // opcode groups
  // ----------------------------------------------------------------
  localparam logic [3:0] HI_ADD = 4'h2;
  localparam logic [3:0] HI_SUM_WITH_CARRY_OP = 4'h3;
  localparam logic [3:0] HI_DIFFERENCE_WITH_BORROW_OP = 4'h9;
  localparam logic [3:0] HI_AND = 4'h5;
  localparam logic [3:0] HI_OR = 4'h4;
  localparam logic [3:0] HI_XOR = 4'h6;
  localparam logic [3:0] LO_DIR_A = 4'h2;
  localparam logic [3:0] LO_DIR_IMM = 4'h3;
  localparam logic [3:0] LO_IMM = 4'h4;
  localparam logic [3:0] LO_DIR = 4'h5;
  localparam logic [2:0] LO_IND = 3'h3;

  // ----------------------------------------------------------------
  // lengths and cycle counts
  // ----------------------------------------------------------------
  localparam logic [1:0] LEN1 = 2'h1;
  localparam logic [1:0] LEN2 = 2'h2;
  localparam logic [1:0] LEN3 = 2'h3;
  localparam logic [2:0] CYC1 = 3'h1;
  localparam logic [2:0] CYC2 = 3'h2;
  localparam logic [2:0] CYC3 = 3'h3;
  localparam logic [2:0] CYC4 = 3'h4;
  localparam logic [2:0] HANDOFF_CNT = 3'h3;

  typedef enum logic [2:0] {OP_ADD, OP_SUM_WITH_CARRY_OP, OP_DIFFERENCE_WITH_BORROW_OP, OP_AND, OP_OR, OP_XOR} alu_op_type;
  typedef enum logic [2:0] {M_REG, M_IND, M_DIR, M_IMM, M_DIR_A, M_DIR_IMM} mode_type;
  typedef enum logic {S_EXEC, S_OTHER} state_type;

  typedef struct packed {
    logic hit;
    alu_op_type op;
    mode_type mode;
    logic [1:0] len;
    logic [2:0] cycles;
  } decode_type;

  typedef struct packed {
    logic rd;
    logic wr;
    logic sfr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mem_req_type;

  typedef struct packed {
    logic [7:0] res;
    logic cy;
    logic ac;
    logic ov;
  } alu_out_type;

  typedef struct packed {
    logic [15:0] page_branch_target;
    logic [15:0] rel_short;
    logic [15:0] rel_long;
    logic [15:0] long_branch_target;
    logic [15:0] immediate_word;
  } branch_type;

  function automatic decode_type decode(input logic [7:0] opc);
    decode_type d;
    logic arith;
    logic lgc;
    arith = (opc[7:4] == HI_ADD) || (opc[7:4] == HI_SUM_WITH_CARRY_OP) || (opc[7:4] == HI_DIFFERENCE_WITH_BORROW_OP);
    lgc = (opc[7:4] == HI_AND) || (opc[7:4] == HI_OR) || (opc[7:4] == HI_XOR);
    d = '{hit: 1'b0, op: OP_ADD, mode: M_REG, len: LEN1, cycles: CYC1};
    case (opc[7:4])
      HI_SUM_WITH_CARRY_OP: d.op = OP_SUM_WITH_CARRY_OP;
      HI_DIFFERENCE_WITH_BORROW_OP: d.op = OP_DIFFERENCE_WITH_BORROW_OP;
      HI_AND: d.op = OP_AND;
      HI_OR: d.op = OP_OR;
      HI_XOR: d.op = OP_XOR;
      default: d.op = OP_ADD;
    endcase
    if (opc[3]) begin
      d.hit = arith || lgc;
    end else if (opc[3:1] == LO_IND) begin
      d = '{hit: arith || lgc, op: d.op, mode: M_IND, len: LEN1, cycles: CYC2};
    end else if (opc[3:0] == LO_DIR) begin
      d = '{hit: arith || lgc, op: d.op, mode: M_DIR, len: LEN2, cycles: CYC2};
    end else if (opc[3:0] == LO_IMM) begin
      d = '{hit: arith || lgc, op: d.op, mode: M_IMM, len: LEN2, cycles: CYC2};
    end else if (opc[3:0] == LO_DIR_A) begin
      d = '{hit: lgc, op: d.op, mode: M_DIR_A, len: LEN2, cycles: CYC3};
    end else if (opc[3:0] == LO_DIR_IMM) begin
      d = '{hit: lgc, op: d.op, mode: M_DIR_IMM, len: LEN3, cycles: CYC4};
    end
    return d;
  endfunction : decode

endpackage : core_pkg

//--- src/alu_unit.sv
// arithmetic and logic unit for the core slice
`timescale 1ns/1ps
`default_nettype none
module alu_unit (
  // operation and operands
  input wire core_pkg::alu_op_type op,
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic cy_in,
  // result and flags
  output var core_pkg::alu_out_type out
);

  logic cin;
  logic [8:0] full;
  logic [4:0] nib;

  always_comb begin
    cin = (op == core_pkg::OP_ADD) ? 1'b0 : cy_in;
    full = 9'h000;
    nib = 5'h00;
    out = '0;
    case (op)
      core_pkg::OP_ADD, core_pkg::OP_SUM_WITH_CARRY_OP: begin
        full = 9'({1'b0, a} + {1'b0, b} + {8'h00, cin});
        nib = 5'({1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin});
        out.res = full[7:0];
        out.cy = full[8];
        out.ac = nib[4];
        out.ov = (a[7] == b[7]) && (full[7] != a[7]);
      end
      core_pkg::OP_DIFFERENCE_WITH_BORROW_OP: begin
        // borrow shows as the ninth bit of the difference
        full = 9'({1'b0, a} - {1'b0, b} - {8'h00, cin});
        nib = 5'({1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin});
        out.res = full[7:0];
        out.cy = full[8];
        out.ac = nib[4];
        out.ov = (a[7] != b[7]) && (full[7] != a[7]);
      end
      core_pkg::OP_AND: out.res = a & b;
      core_pkg::OP_OR: out.res = a | b;
      core_pkg::OP_XOR: out.res = a ^ b;
      default: out.res = a;
    endcase
  end

endmodule : alu_unit
`default_nettype wire

//--- src/branch_target.sv
// branch and immediate word target computation from captured instruction bytes
`timescale 1ns/1ps
`default_nettype none
module branch_target (
  // captured instruction
  input wire logic [15:0] pc,
  input wire logic [7:0] opcode,
  input wire logic [7:0] byte1,
  input wire logic [7:0] byte2,
  // targets
  output var core_pkg::branch_type tgt
);

  logic [15:0] next2;
  logic [15:0] next3;

  always_comb begin
    next2 = 16'(pc + 16'h0002);
    next3 = 16'(pc + 16'h0003);
    // page stays that of the following instruction [RULE8]
    tgt.page_branch_target = {next2[15:core_pkg::PAGE_BITS], opcode[7:5], byte1};
    // signed offset from the following instruction [RULE9]
    tgt.rel_short = 16'(next2 + {{8{byte1[7]}}, byte1});
    tgt.rel_long = 16'(next3 + {{8{byte2[7]}}, byte2});
    tgt.long_branch_target = {byte1, byte2}; // [RULE10]
    tgt.immediate_word = {byte1, byte2}; // [RULE11]
  end

endmodule : branch_target
`default_nettype wire

//--- src/core_slice.sv
// core slice: operand registers, stack pointer, flags word and arith/logic execution
`timescale 1ns/1ps
`default_nettype none
module core_slice (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // program memory, read data valid in the same cycle
  output logic [15:0] code_addr,
  input wire logic [7:0] code_rdata,
  // data and sfr space, read data valid in the same cycle
  output var core_pkg::mem_req_type mem_req,
  input wire logic [7:0] mem_rdata,
  // hand-off to the remaining decode logic
  output logic other_valid,
  output logic [7:0] other_opcode,
  input wire logic other_done,
  input wire logic [15:0] other_next_pc,
  output var core_pkg::branch_type branch,
  // stack store from the remaining logic
  input wire logic push_valid,
  input wire logic [7:0] push_byte,
  // sfr port for the remaining logic
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  core_pkg::state_type state_q;
  core_pkg::state_type state_d;
  logic [15:0] pc_q;
  logic [15:0] pc_d;
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic [7:0] opc_q;
  logic [7:0] opc_d;
  logic [7:0] addr_q;
  logic [7:0] addr_d;
  logic [7:0] mem_q;
  logic [7:0] mem_d;
  logic [7:0] res_q;
  logic [7:0] res_d;
  logic [7:0] byte1_q;
  logic [7:0] byte1_d;
  logic [7:0] byte2_q;
  logic [7:0] byte2_d;
  logic [7:0] main_operand_reg_q;
  logic [7:0] main_operand_reg_d;
  logic [7:0] second_operand_reg_q;
  logic [7:0] second_operand_reg_d;
  logic [7:0] stack_pointer_q;
  logic [7:0] stack_pointer_d;
  logic [7:0] flags_word_q;
  logic [7:0] flags_word_d;

  // ----------------------------------------------------------------
  // decode and access helpers
  // ----------------------------------------------------------------
  logic [7:0] cur_opc;
  core_pkg::decode_type cur_dec;
  logic last;
  logic [1:0] bank_select_field;
  logic [7:0] flags_view;
  logic [8:0] req_int;
  logic [8:0] port_int;
  logic [7:0] rdata;
  core_pkg::mem_req_type req;
  logic [7:0] alu_a;
  logic [7:0] alu_b;
  core_pkg::alu_out_type alu;
  logic int_wr;
  logic [7:0] int_addr;
  logic [7:0] int_data;

  // returns {hit, value} for the registers held in this slice
  function automatic logic [8:0] int_read(input logic [7:0] a, input logic [7:0] acc,
                                          input logic [7:0] sec, input logic [7:0] sp,
                                          input logic [7:0] flg);
    logic [8:0] r;
    r = 9'h000;
    case (a)
      core_pkg::SP_ADDR: r = {1'b1, sp};
      core_pkg::FLAGS_ADDR: r = {1'b1, flg};
      core_pkg::ACC_ADDR: r = {1'b1, acc};
      core_pkg::SECOND_ADDR: r = {1'b1, sec};
      default: r = 9'h000;
    endcase
    return r;
  endfunction : int_read

  assign cur_opc = (cnt_q == 3'h0) ? code_rdata : opc_q;
  assign cur_dec = core_pkg::decode(cur_opc);
  assign last = (cnt_q == 3'(cur_dec.cycles - 3'h1)); // [RULE24]
  assign bank_select_field = flags_word_q[core_pkg::BANK_HI:core_pkg::BANK_LO];
  // parity always follows the main operand; a written parity bit does not stick
  assign flags_view = {flags_word_q[7:1], ^main_operand_reg_q};
  assign code_addr = 16'(pc_q + {13'h0000, cnt_q});
  assign other_valid = (state_q == core_pkg::S_OTHER) && (cnt_q == core_pkg::HANDOFF_CNT);
  assign other_opcode = opc_q;

  // ----------------------------------------------------------------
  // data space request
  // ----------------------------------------------------------------
  always_comb begin
    req = '0;
    if (state_q == core_pkg::S_OTHER) begin
      if (push_valid) begin
        // store goes to the already incremented location [RULE3]
        req.wr = 1'b1;
        req.addr = 8'(stack_pointer_q + 8'h01);
        req.wdata = push_byte;
      end
    end else if (cur_dec.hit) begin
      case (cur_dec.mode)
        core_pkg::M_REG: begin
          req.rd = 1'b1;
          req.addr = {3'h0, bank_select_field, cur_opc[2:0]}; // [RULE7] [RULE23]
        end
        core_pkg::M_IND: begin
          req.rd = 1'b1;
          if (cnt_q == 3'h0) begin
            req.addr = {3'h0, bank_select_field, 2'h0, cur_opc[0]}; // [RULE6]
          end else begin
            req.addr = addr_q; // full DATA range, never sfr [RULE6]
          end
        end
        core_pkg::M_DIR, core_pkg::M_DIR_A, core_pkg::M_DIR_IMM: begin
          if (cnt_q == 3'h1) begin
            req.rd = 1'b1;
            req.addr = code_rdata;
            req.sfr = code_rdata[7]; // [RULE5]
          end else if (last && cur_dec.mode != core_pkg::M_DIR) begin
            req.wr = 1'b1;
            req.addr = addr_q;
            req.sfr = addr_q[7]; // [RULE5]
            req.wdata = res_q;
          end
        end
        default: req = '0;
      endcase
    end
  end

  assign req_int = int_read(req.addr, main_operand_reg_q, second_operand_reg_q,
                            stack_pointer_q, flags_view);
  assign port_int = int_read(sfr_addr, main_operand_reg_q, second_operand_reg_q,
                             stack_pointer_q, flags_view);
  assign rdata = (req.sfr && req_int[8]) ? req_int[7:0] : mem_rdata;
  assign sfr_rdata = port_int[7:0];

  // slice-held registers are never put on the outer data port
  always_comb begin
    mem_req = req;
    if (req.sfr && req_int[8]) begin
      mem_req.rd = 1'b0;
      mem_req.wr = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // operand selection and alu
  // ----------------------------------------------------------------
  always_comb begin
    alu_a = main_operand_reg_q;
    alu_b = rdata;
    case (cur_dec.mode)
      core_pkg::M_IMM: alu_b = code_rdata; // [RULE11]
      // direct byte combined with the main operand, not with itself
      core_pkg::M_DIR_A: alu_b = rdata;
      core_pkg::M_DIR_IMM: begin
        alu_a = mem_q;
        alu_b = code_rdata;
      end
      default: alu_a = main_operand_reg_q;
    endcase
  end

  alu_unit u_alu (
    .op(cur_dec.op),
    .a(alu_a),
    .b(alu_b),
    .cy_in(flags_word_q[core_pkg::CY_BIT]),
    .out(alu)
  );

  branch_target u_branch (
    .pc(pc_q),
    .opcode(opc_q),
    .byte1(byte1_q),
    .byte2(byte2_q),
    .tgt(branch)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    pc_d = pc_q;
    cnt_d = cnt_q;
    opc_d = opc_q;
    addr_d = addr_q;
    mem_d = mem_q;
    res_d = res_q;
    byte1_d = byte1_q;
    byte2_d = byte2_q;
    main_operand_reg_d = main_operand_reg_q;
    second_operand_reg_d = second_operand_reg_q;
    stack_pointer_d = stack_pointer_q;
    flags_word_d = flags_word_q;
    int_wr = 1'b0;
    int_addr = sfr_addr;
    int_data = sfr_wdata;
    case (state_q)
      core_pkg::S_EXEC: begin
        if (cnt_q == 3'h0) begin
          opc_d = code_rdata;
        end
        if (!cur_dec.hit) begin
          // nothing architectural changes here for foreign opcodes [RULE25]
          state_d = core_pkg::S_OTHER;
          cnt_d = 3'h1;
        end else begin
          if (cur_dec.mode == core_pkg::M_IND && cnt_q == 3'h0) begin
            addr_d = rdata;
          end
          if (cnt_q == 3'h1) begin
            addr_d = (cur_dec.mode == core_pkg::M_IND) ? addr_q : code_rdata;
            mem_d = rdata;
          end
          if ((cur_dec.mode == core_pkg::M_DIR_A && cnt_q == 3'h1) ||
              (cur_dec.mode == core_pkg::M_DIR_IMM && cnt_q == 3'h2)) begin
            res_d = alu.res; // [RULE17] [RULE19] [RULE21] [RULE22]
          end
          if (last && cur_dec.mode inside {core_pkg::M_REG, core_pkg::M_IND,
                                           core_pkg::M_DIR, core_pkg::M_IMM}) begin
            // [RULE13] [RULE14] [RULE15] [RULE16] [RULE18] [RULE20]
            main_operand_reg_d = alu.res; // [RULE1]
            if (cur_dec.op inside {core_pkg::OP_ADD, core_pkg::OP_SUM_WITH_CARRY_OP, core_pkg::OP_DIFFERENCE_WITH_BORROW_OP}) begin
              flags_word_d[core_pkg::CY_BIT] = alu.cy;
              flags_word_d[core_pkg::AC_BIT] = alu.ac;
              flags_word_d[core_pkg::OV_BIT] = alu.ov;
            end
          end
          if (req.wr && req.sfr && req_int[8]) begin
            int_wr = 1'b1;
            int_addr = req.addr;
            int_data = req.wdata;
          end
          if (last) begin
            // the next opcode is fetched only after the full count [RULE24]
            pc_d = 16'(pc_q + {14'h0000, cur_dec.len});
            cnt_d = 3'h0;
          end else begin
            cnt_d = 3'(cnt_q + 3'h1);
          end
        end
      end
      core_pkg::S_OTHER: begin
        // gather two operand bytes, then hand the instruction over
        if (cnt_q == 3'h1) begin
          byte1_d = code_rdata;
        end
        if (cnt_q == 3'h2) begin
          byte2_d = code_rdata;
        end
        if (cnt_q != core_pkg::HANDOFF_CNT) begin
          cnt_d = 3'(cnt_q + 3'h1);
        end else if (other_done) begin
          state_d = core_pkg::S_EXEC;
          pc_d = other_next_pc;
          cnt_d = 3'h0;
        end
        int_wr = sfr_wr;
        if (push_valid) begin
          stack_pointer_d = 8'(stack_pointer_q + 8'h01); // [RULE3]
        end
      end
      default: begin
        state_d = core_pkg::S_EXEC;
        cnt_d = 3'h0;
      end
    endcase
    // sfr writes land after arithmetic so a written flags word wins
    if (int_wr) begin
      case (int_addr)
        core_pkg::SP_ADDR: stack_pointer_d = int_data;
        core_pkg::FLAGS_ADDR: flags_word_d = int_data; // [RULE12]
        core_pkg::ACC_ADDR: main_operand_reg_d = int_data; // [RULE1]
        core_pkg::SECOND_ADDR: second_operand_reg_d = int_data; // [RULE2]
        default: flags_word_d = flags_word_d;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state_q <= core_pkg::S_EXEC;
      pc_q <= core_pkg::PC_RESET;
      cnt_q <= 3'h0;
      opc_q <= 8'h00;
      addr_q <= 8'h00;
      mem_q <= 8'h00;
      res_q <= 8'h00;
      byte1_q <= 8'h00;
      byte2_q <= 8'h00;
      main_operand_reg_q <= core_pkg::ACC_RESET; // [RULE1]
      second_operand_reg_q <= core_pkg::SECOND_RESET; // [RULE2]
      stack_pointer_q <= core_pkg::SP_RESET; // [RULE4]
      flags_word_q <= core_pkg::FLAGS_RESET;
    end else begin
      state_q <= state_d;
      pc_q <= pc_d;
      cnt_q <= cnt_d;
      opc_q <= opc_d;
      addr_q <= addr_d;
      mem_q <= mem_d;
      res_q <= res_d;
      byte1_q <= byte1_d;
      byte2_q <= byte2_d;
      main_operand_reg_q <= main_operand_reg_d;
      second_operand_reg_q <= second_operand_reg_d;
      stack_pointer_q <= stack_pointer_d;
      flags_word_q <= flags_word_d;
    end
  end

endmodule : core_slice
`default_nettype wire

//--- tb/core_slice_checker.sv
// checker: port-level properties of the core slice
`timescale 1ns/1ps
`default_nettype none
module core_slice_checker (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // watched ports
  input wire logic [15:0] code_addr,
  input wire core_pkg::mem_req_type mem_req,
  input wire logic other_valid,
  input wire logic [7:0] other_opcode,
  input wire logic other_done,
  input wire logic [15:0] other_next_pc,
  input wire logic push_valid,
  input wire logic [7:0] push_byte,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_rdata
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  AST_START_ZERO: assert property ($rose(resetn) |-> code_addr == 16'h0000)
    else $error("first fetch not at zero");
  AST_SFR_SPACE: assert property (mem_req.sfr |-> mem_req.addr[7] &&
    !((mem_req.rd || mem_req.wr) && mem_req.addr inside {8'h81, 8'hD0, 8'hE0, 8'hF0}))
    else $error("sfr access misrouted");
  AST_PUSH_ADDR: assert property (other_valid && push_valid && sfr_addr == 8'h81 |->
    mem_req.wr && !mem_req.sfr && mem_req.addr == sfr_rdata + 8'h01 &&
    mem_req.wdata == push_byte) else $error("push address or data wrong");
  AST_SP_BUMP: assert property (other_valid && push_valid && !sfr_wr && sfr_addr == 8'h81
    |=> (sfr_addr != 8'h81 || sfr_rdata == $past(sfr_rdata) + 8'h01))
    else $error("stack pointer not bumped");
  AST_RESUME_PC: assert property (other_valid && other_done |=>
    code_addr == $past(other_next_pc)) else $error("resume address wrong");
  AST_HOLD_OPCODE: assert property (other_valid && !other_done |=>
    other_valid && $stable(other_opcode)) else $error("hand-over dropped");
  AST_NO_STRAY_WR: assert property (other_valid && !push_valid && !sfr_wr |->
    !mem_req.wr) else $error("write during hand-over");
  AST_BYTES_FIRST: assert property ($rose(other_valid) |->
    $past(code_addr) == $past(code_addr, 2) + 16'h0001) else $error("operand fetch order");
  AST_MAIN_KEPT: assert property (other_valid && !sfr_wr && sfr_addr == 8'hE0 |=>
    (sfr_addr != 8'hE0 || $stable(sfr_rdata))) else $error("main changed by foreign op");
endmodule : core_slice_checker
`default_nettype wire

//--- tb/mem_model.sv
// partner model: async program rom and one byte store for data and sfr space
`timescale 1ns/1ps
`default_nettype none
module mem_model (
  // clock
  input wire logic sys_clk,
  // program side
  input wire logic [15:0] code_addr,
  output logic [7:0] code_rdata,
  // data side
  input wire core_pkg::mem_req_type mem_req,
  output logic [7:0] mem_rdata
);
  logic [7:0] code [0:255];
  logic [7:0] data [0:255];
  // only one code page is modelled; beyond it the inverted low address byte, never stored code
  assign code_rdata = (code_addr[15:8] == 8'h00) ? code[code_addr[7:0]] : ~code_addr[7:0];
  // limitation: sfr and upper data share bytes; an idle bus shows inverted data
  assign mem_rdata = mem_req.rd ? data[mem_req.addr] : ~data[mem_req.addr];
  always @(posedge sys_clk) begin
    if (mem_req.wr) begin
      data[mem_req.addr] <= mem_req.wdata;
    end
  end
endmodule : mem_model
`default_nettype wire

//--- tb/tb.sv
// testbench: reset values, arithmetic program, hand-over, push and sfr writes
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin n_errors++; \
  $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module tb;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [15:0] code_addr;
  logic [7:0] code_rdata;
  core_pkg::mem_req_type mem_req;
  logic [7:0] mem_rdata;
  logic other_valid;
  logic [7:0] other_opcode;
  logic other_done = 1'b0;
  logic [15:0] other_next_pc = 16'h0000;
  core_pkg::branch_type branch;
  logic push_valid = 1'b0;
  logic [7:0] push_byte = 8'h00;
  logic sfr_wr = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  int n_errors = 0;
  int comparisons = 0;
  logic [7:0] prog [0:20] = '{8'h24, 8'h5A, 8'h2A, 8'h95, 8'h30, 8'h64, 8'hFF, 8'h34, 8'h70,
    8'h38, 8'h47, 8'h45, 8'h90, 8'h53, 8'h31, 8'h0F, 8'h62, 8'h31, 8'hA5, 8'h80, 8'hFE};

  always #2.5 sys_clk = ~sys_clk;

  core_slice u_core_slice (.sys_clk(sys_clk), .resetn(resetn), .code_addr(code_addr),
    .code_rdata(code_rdata), .mem_req(mem_req), .mem_rdata(mem_rdata),
    .other_valid(other_valid), .other_opcode(other_opcode), .other_done(other_done),
    .other_next_pc(other_next_pc), .branch(branch), .push_valid(push_valid),
    .push_byte(push_byte), .sfr_wr(sfr_wr), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata));
  mem_model u_mem_model (.sys_clk(sys_clk), .code_addr(code_addr), .code_rdata(code_rdata),
    .mem_req(mem_req), .mem_rdata(mem_rdata));

  task automatic check_sfr(input string nm, input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    sfr_addr <= a;
    #1;
    `CHECK(nm, exp, sfr_rdata)
  endtask : check_sfr

  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    sfr_wr <= 1'b1;
    sfr_addr <= a;
    sfr_wdata <= d;
    @(posedge sys_clk);
    sfr_wr <= 1'b0;
  endtask : sfr_write

  task automatic test_done();
    if (n_errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done

  task automatic test_reset_values();
    repeat (7) @(posedge sys_clk);
    check_sfr("sp reset", 8'h81, 8'h07);
    check_sfr("main reset", 8'hE0, 8'h00);
    check_sfr("second reset", 8'hF0, 8'h00);
    check_sfr("flags reset", 8'hD0, 8'h00);
  endtask : test_reset_values

  task automatic test_program();
    int n;
    @(posedge sys_clk);
    resetn <= 1'b1;
    n = 0;
    while (other_valid !== 1'b1 && n < 60) begin
      @(posedge sys_clk);
      n++;
      #1;
    end
    `CHECK("hand-over cycle", 24, n)
    `CHECK("opcode", 8'hA5, other_opcode)
    `CHECK("direct byte", 8'h3A, u_mem_model.data[8'h31])
    `CHECK("imm word", 16'h80FE, branch.immediate_word)
    `CHECK("long target", 16'h80FE, branch.long_branch_target)
    `CHECK("rel short", 16'hFF94, branch.rel_short)
    `CHECK("rel long", 16'h0013, branch.rel_long)
    `CHECK("page target", 16'h0580, branch.page_branch_target)
    check_sfr("main", 8'hE0, 8'h35);
    check_sfr("arith flags", 8'hD0, 8'h40);
  endtask : test_program

  task automatic test_handover();
    @(posedge sys_clk);
    push_valid <= 1'b1;
    push_byte <= 8'h77;
    sfr_addr <= 8'h81;
    @(posedge sys_clk);
    push_valid <= 1'b0;
    #1;
    `CHECK("stack byte", 8'h77, u_mem_model.data[8'h08])
    `CHECK("stack ptr", 8'h08, sfr_rdata)
    sfr_write(8'hF0, 8'h3C);
    check_sfr("second", 8'hF0, 8'h3C);
    sfr_write(8'hE0, 8'h80);
    sfr_write(8'hD0, 8'h08);
    check_sfr("flags", 8'hD0, 8'h09);
    check_sfr("main write", 8'hE0, 8'h80);
  endtask : test_handover

  task automatic test_bank_switch();
    @(posedge sys_clk);
    other_done <= 1'b1;
    other_next_pc <= 16'h0020;
    @(posedge sys_clk);
    other_done <= 1'b0;
    #1;
    `CHECK("resume addr", 16'h0020, code_addr)
    `CHECK("bank reg addr", 8'h09, mem_req.addr)
    check_sfr("bank add", 8'hE0, 8'h83);
    check_sfr("flags after add", 8'hD0, 8'h09);
  endtask : test_bank_switch

  initial begin
    for (int i = 0; i < 256; i++) begin
      u_mem_model.code[i] = 8'h00;
      u_mem_model.data[i] = i[7:0] ^ 8'hC3;
    end
    foreach (prog[i]) u_mem_model.code[i] = prog[i];
    u_mem_model.code[8'h20] = 8'h29;
    u_mem_model.code[8'h21] = 8'hA5;
    u_mem_model.data[8'h00] = 8'h00;
    u_mem_model.data[8'h01] = 8'h40;
    u_mem_model.data[8'h02] = 8'h11;
    u_mem_model.data[8'h09] = 8'h03;
    u_mem_model.data[8'h30] = 8'h0B;
    u_mem_model.data[8'h31] = 8'hFF;
    u_mem_model.data[8'h40] = 8'h05;
    u_mem_model.data[8'h90] = 8'h20;
    test_reset_values();
    test_program();
    test_handover();
    test_bank_switch();
    test_done();
  end

  // the whole run needs under a hundred cycles
  initial begin
    repeat (400) @(posedge sys_clk);
    n_errors++;
    test_done();
  end
endmodule : tb

bind core_slice core_slice_checker u_core_slice_checker (.sys_clk(sys_clk), .resetn(resetn),
  .code_addr(code_addr), .mem_req(mem_req), .other_valid(other_valid),
  .other_opcode(other_opcode), .other_done(other_done), .other_next_pc(other_next_pc),
  .push_valid(push_valid), .push_byte(push_byte), .sfr_wr(sfr_wr), .sfr_addr(sfr_addr),
  .sfr_rdata(sfr_rdata));
`default_nettype wire
